// ---- rtl/pbb_bridge.sv ----
// Main-bus to divided-clock peripheral bus bridge
`timescale 1ns/1ps
module pbb_bridge
(
	// Clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         rst_n_in,
	// Clock ratio settings, core cycles per slow cycle
	input  wire logic [3:0]                   pclk_div_in,
	input  wire logic [3:0]                   flash_interface_clock_div_in,
	// Main bus slave side
	input  wire logic                         req_valid_in,
	input  wire pbb_pkg::pbb_req_t            req_in,
	output logic                              req_ready_out,
	output logic                              rsp_valid_out,
	output logic [pbb_pkg::DATA_W-1:0]        rsp_rdata_out,
	// Contention from other masters
	input  wire logic                         contend_in,
	// Peripheral side
	output logic                              per_sel_out,
	output pbb_pkg::pbb_req_t                 per_req_out,
	output logic [2:0]                        per_bus_out,
	input  wire logic [pbb_pkg::DATA_W-1:0]   per_rdata_in,
	// Status
	output logic                              wq_empty_out
);
	pbb_pkg::pbb_state_t st_q, st_d;
	pbb_pkg::pbb_req_t   cur_q, cur_d, wq_rd;
	pbb_pkg::pbb_dec_t   dec;
	logic [3:0] phase_q, phase_d, fphase_q, fphase_d, slow_phase, div;
	logic [3:0] cnt_q, cnt_d;
	logic [pbb_pkg::WQ_PTR_W:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [pbb_pkg::SYNC_STAGES-1:0] rd_sync_q, rd_sync_d;
	logic [pbb_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [2:0] bus_q, bus_d;
	logic cur_from_q_q, cur_from_q_d, rsp_q, rsp_d;
	logic wq_full, wq_empty, wq_we, pop_pend_q, pop_pend_d, slow_edge;

	// Bus and cycle count from the upper address bits
	always_comb
	begin
		dec.bus = req_in.addr[15:13];
		dec.cycles = pbb_pkg::PER_CYC_RST + {2'h0, req_in.addr[12]};
		dec.no_sync = ((req_in.addr & pbb_pkg::BUSERR_MASK)
			== pbb_pkg::BUSERR_BASE);
	end

	assign wq_full = (wr_ptr_q[pbb_pkg::WQ_PTR_W] != rd_ptr_q[pbb_pkg::WQ_PTR_W])
		&& (wr_ptr_q[pbb_pkg::WQ_PTR_W-1:0] == rd_ptr_q[pbb_pkg::WQ_PTR_W-1:0]);
	assign wq_empty = (wr_ptr_q == rd_ptr_q);
	assign wq_empty_out = wq_empty;
	// Writes post into the queue; reads wait until it drains
	assign req_ready_out = req_in.wr ? !wq_full
		: (wq_empty && st_q == pbb_pkg::ST_IDLE && !pop_pend_q);
	assign wq_we = req_valid_in && req_in.wr && !wq_full;

	pbb_wq_mem u_mem
	(
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.we_in     (wq_we),
		.waddr_in  (wr_ptr_q[pbb_pkg::WQ_PTR_W-1:0]),
		.wdata_in  (req_in),
		.raddr_in  (rd_ptr_q[pbb_pkg::WQ_PTR_W-1:0]),
		.rdata_out (wq_rd)
	);

	// Divided clock phase, which decides the sync wait
	assign div = (bus_q == pbb_pkg::BUS_FLASH) ? flash_interface_clock_div_in : pclk_div_in;
	assign slow_phase = (bus_q == pbb_pkg::BUS_FLASH) ? fphase_q : phase_q;
	assign slow_edge = (div <= 4'h1) || (slow_phase == 4'h0);

	always_comb
	begin
		phase_d = (phase_q + 4'h1 >= pclk_div_in) ? 4'h0 : phase_q + 4'h1;
		fphase_d = (fphase_q + 4'h1 >= flash_interface_clock_div_in) ? 4'h0 : fphase_q + 4'h1;
		st_d = st_q;
		cur_d = cur_q;
		cnt_d = cnt_q;
		wr_ptr_d = wr_ptr_q + {{pbb_pkg::WQ_PTR_W{1'b0}}, wq_we};
		rd_ptr_d = rd_ptr_q;
		rd_sync_d = rd_sync_q;
		rdata_d = rdata_q;
		bus_d = bus_q;
		cur_from_q_d = cur_from_q_q;
		pop_pend_d = 1'b0;
		rsp_d = 1'b0;
		case (st_q)
			pbb_pkg::ST_IDLE:
			begin
				if (!wq_empty && !pop_pend_q)
				begin
					// Memory read data lands next cycle
					pop_pend_d = 1'b1;
				end
				else if (pop_pend_q)
				begin
					cur_d = wq_rd;
					bus_d = wq_rd.addr[15:13];
					cur_from_q_d = 1'b1;
					rd_ptr_d = rd_ptr_q + {{pbb_pkg::WQ_PTR_W{1'b0}}, 1'b1};
					cnt_d = {1'b0, pbb_pkg::PER_CYC_RST}
						+ {3'h0, wq_rd.addr[12]};
					st_d = (pbb_pkg::SYNC_BUS_MASK[wq_rd.addr[15:13]]
						&& (wq_rd.addr & pbb_pkg::BUSERR_MASK)
						!= pbb_pkg::BUSERR_BASE)
						? pbb_pkg::ST_SYNC : pbb_pkg::ST_PER;
				end
				else if (req_valid_in && !req_in.wr && req_ready_out)
				begin
					cur_d = req_in;
					bus_d = dec.bus;
					cur_from_q_d = 1'b0;
					cnt_d = {1'b0, dec.cycles};
					st_d = (pbb_pkg::SYNC_BUS_MASK[dec.bus] && !dec.no_sync)
						? pbb_pkg::ST_SYNC : pbb_pkg::ST_PER;
				end
			end
			pbb_pkg::ST_SYNC:
			begin
				// Wait for slow clock edge with contend_in low; at most one slow period without contention
				if (slow_edge && !contend_in)
					st_d = pbb_pkg::ST_PER;
			end
			pbb_pkg::ST_PER:
			begin
				// Peripheral bus cycles counted in core cycles
				if (cnt_q <= 4'h1)
				begin
					// Posted writes leave the last read data standing
					if (!cur_from_q_q)
						rdata_d = per_rdata_in;
					rd_sync_d = '0;
					st_d = cur_from_q_q ? pbb_pkg::ST_IDLE
						: pbb_pkg::ST_BACK;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			pbb_pkg::ST_BACK:
			begin
				// Resynchronise completion into the core domain
				rd_sync_d = {rd_sync_q[pbb_pkg::SYNC_STAGES-2:0], 1'b1};
				if (rd_sync_q[pbb_pkg::SYNC_STAGES-2])
					st_d = pbb_pkg::ST_DONE;
			end
			pbb_pkg::ST_DONE:
			begin
				rsp_d = 1'b1;
				st_d = pbb_pkg::ST_IDLE;
			end
			default:
				st_d = pbb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			st_q <= pbb_pkg::ST_IDLE;
			cur_q <= '0;
			cnt_q <= 4'h0;
			phase_q <= 4'h0;
			fphase_q <= 4'h0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			rd_sync_q <= '0;
			rdata_q <= '0;
			bus_q <= 3'h0;
			cur_from_q_q <= 1'b0;
			pop_pend_q <= 1'b0;
			rsp_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cur_q <= cur_d;
			cnt_q <= cnt_d;
			phase_q <= phase_d;
			fphase_q <= fphase_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			rd_sync_q <= rd_sync_d;
			rdata_q <= rdata_d;
			bus_q <= bus_d;
			cur_from_q_q <= cur_from_q_d;
			pop_pend_q <= pop_pend_d;
			rsp_q <= rsp_d;
		end
	end

	assign per_sel_out = (st_q == pbb_pkg::ST_PER);
	assign per_req_out = cur_q;
	assign per_bus_out = bus_q;
	assign rsp_valid_out = rsp_q;
	assign rsp_rdata_out = rdata_q;

	// Checks
	property p_rd_after_writes;
		@(posedge clk_in) disable iff (!rst_n_in)
		(req_valid_in && !req_in.wr && req_ready_out) |-> wq_empty;
	endproperty
	a_rd_after_writes: assert property (p_rd_after_writes)
		else $error("Read accepted with posted writes pending");

	property p_sync_bounded;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_q == pbb_pkg::ST_SYNC && !contend_in && div <= 4'h8)
		|-> ##[1:8] (st_q != pbb_pkg::ST_SYNC);
	endproperty
	a_sync_bounded: assert property (p_sync_bounded)
		else $error("Sync wait exceeded one slow period");

	property p_sync_on_edge;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_q == pbb_pkg::ST_SYNC && slow_edge && !contend_in)
		|=> (st_q == pbb_pkg::ST_PER);
	endproperty
	a_sync_on_edge: assert property (p_sync_on_edge)
		else $error("Sync wait missed the slow clock edge");

	property p_back_len;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(st_q == pbb_pkg::ST_BACK) |-> (st_q == pbb_pkg::ST_BACK)[*3]
		##1 (st_q == pbb_pkg::ST_DONE) ##1 rsp_valid_out;
	endproperty
	a_back_len: assert property (p_back_len)
		else $error("Read data resync length wrong");

	property p_rsp_only_reads;
		@(posedge clk_in) disable iff (!rst_n_in)
		rsp_valid_out |-> !cur_q.wr;
	endproperty
	a_rsp_only_reads: assert property (p_rsp_only_reads)
		else $error("Response raised for a write");

	property p_no_sync_buserr;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_q == pbb_pkg::ST_IDLE && req_valid_in && !req_in.wr
		&& req_ready_out && dec.no_sync && !pop_pend_q && wq_empty)
		|=> (st_q == pbb_pkg::ST_PER);
	endproperty
	a_no_sync_buserr: assert property (p_no_sync_buserr)
		else $error("Sync inserted for bus-error register");
endmodule

// ---- rtl/pbb_pkg.sv ----
// Package for the peripheral bus access bridge
// Function
// - Access takes main-bus plus sync plus peripheral-bus cycles; reads here add 3 resync cycles and 1 done cycle.
// - Peripheral-bus cycle count comes from the register actually addressed.
// - Sync cycles only on peripheral buses 2, 3, 6, not bus-error registers.
// - Sync length follows clock ratio and access phase to the slow clock.
// - Fast core: main-bus plus sync cycles fit within one slow clock period; here the two can take one slow period plus one core cycle.
// - Slow core: next access starts the core cycle after completion.
// - Stated counts hold only without fetch or transfer contention.
// - Posted writes finish in order; a read returns after all prior writes.
package pbb_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int NUM_BUSES = 8;
	localparam int MAIN_CYC = 1;
	localparam logic [3:0] PCLK_DIV_RST = 4'h2;
	localparam logic [3:0] FLASH_INTERFACE_CLOCK_DIV_RST = 4'h4;
	localparam logic [2:0] PER_CYC_RST = 3'h2;
	localparam int WQ_DEPTH = 4;
	localparam int WQ_PTR_W = 2;
	localparam int SYNC_STAGES = 3;
	localparam logic [2:0] BUS_FLASH = 3'h6;
	localparam logic [7:0] SYNC_BUS_MASK = 8'h4c;
	localparam logic [ADDR_W-1:0] BUSERR_BASE = 24'h081300;
	localparam logic [ADDR_W-1:0] BUSERR_MASK = 24'hffff00;

	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pbb_req_t;

	typedef struct packed {
		logic [2:0] bus;
		logic [2:0] cycles;
		logic       no_sync;
	} pbb_dec_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SYNC = 5'b00010,
		ST_PER  = 5'b00100,
		ST_BACK = 5'b01000,
		ST_DONE = 5'b10000
	} pbb_state_t;
endpackage

// ---- rtl/pbb_wq_mem.sv ----
// Small posted-write memory with registered read data
`timescale 1ns/1ps
module pbb_wq_mem
(
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	// Write side
	input  wire logic                  we_in,
	input  wire logic [pbb_pkg::WQ_PTR_W-1:0] waddr_in,
	input  wire pbb_pkg::pbb_req_t     wdata_in,
	// Read side
	input  wire logic [pbb_pkg::WQ_PTR_W-1:0] raddr_in,
	output pbb_pkg::pbb_req_t          rdata_out
);
	pbb_pkg::pbb_req_t mem_q [pbb_pkg::WQ_DEPTH];
	pbb_pkg::pbb_req_t rdata_q;

	always_ff @(posedge clk_in)
	begin
		if (we_in)
			mem_q[waddr_in] <= wdata_in;
		if (!rst_n_in)
			rdata_q <= '0;
		else
			rdata_q <= mem_q[raddr_in];
	end

	assign rdata_out = rdata_q;
endmodule

// ---- verification/pbb_per_model.sv ----
// Peripheral-bus register model standing behind the bridge
`timescale 1ns/1ps
module pbb_per_model
(
	// Clock
	input  wire logic                  clk_in,
	// Bus from the bridge
	input  wire logic                  per_sel_in,
	input  wire pbb_pkg::pbb_req_t     per_req_in,
	// Read data back
	output logic [pbb_pkg::DATA_W-1:0] per_rdata_out
);
	logic [pbb_pkg::DATA_W-1:0] mem [16];
	logic [pbb_pkg::DATA_W-1:0] junk_q = 32'h5a5a5a5a;

	// Toggling junk when idle, so stale data never looks right
	always_ff @(posedge clk_in)
	begin
		junk_q <= ~junk_q;
		if (per_sel_in && per_req_in.wr)
			mem[per_req_in.addr[5:2]] <= per_req_in.wdata;
	end

	assign per_rdata_out = (per_sel_in && !per_req_in.wr) ?
		mem[per_req_in.addr[5:2]] : junk_q;
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the peripheral bus bridge
`timescale 1ns/1ps
module tb;
	logic              clk_in = 1'b0;
	logic              rst_n_in = 1'b0;
	logic [3:0]        pclk_div_in = 4'h4;
	logic [3:0]        flash_interface_clock_div_in = 4'h8;
	logic              req_valid_in = 1'b0;
	pbb_pkg::pbb_req_t req_in = '0;
	logic              contend_in = 1'b0;
	logic              req_ready_out;
	logic              rsp_valid_out;
	logic              per_sel_out;
	logic              wq_empty_out;
	logic [31:0]       rsp_rdata_out;
	logic [31:0]       per_rdata_in;
	pbb_pkg::pbb_req_t per_req_out;
	logic [2:0]        per_bus_out;
	logic [2:0]        bus_seen;
	int                fail_count = 0;
	int                comparisons = 0;
	int                lat;

	always #20 clk_in = ~clk_in;

	pbb_bridge u_pbb_bridge (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.pclk_div_in(pclk_div_in), .flash_interface_clock_div_in(flash_interface_clock_div_in),
		.req_valid_in(req_valid_in), .req_in(req_in),
		.req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_rdata_out(rsp_rdata_out), .contend_in(contend_in),
		.per_sel_out(per_sel_out), .per_req_out(per_req_out),
		.per_bus_out(per_bus_out), .per_rdata_in(per_rdata_in),
		.wq_empty_out(wq_empty_out));

	pbb_per_model u_pbb_per_model (.clk_in(clk_in),
		.per_sel_in(per_sel_out), .per_req_in(per_req_out),
		.per_rdata_out(per_rdata_in));

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request held until accepted; valid stays up for the next call
	task automatic send(input logic wr, input logic [23:0] a,
		output logic rdy0);
		@(negedge clk_in);
		req_valid_in = 1'b1;
		req_in = '{wr, a, {8'ha5, a}};
		#1;
		rdy0 = req_ready_out;
		while (req_ready_out !== 1'b1)
		begin
			@(negedge clk_in);
			#1;
		end
		@(posedge clk_in);
	endtask

	task automatic rd(input logic [23:0] a, input int lo, input int hi,
		input logic r0);
		logic rdy0;
		send(1'b0, a, rdy0);
		chk("read_ready", r0, rdy0);
		lat = 0;
		do
		begin
			@(negedge clk_in);
			lat++;
			if (lat == 1)
				req_valid_in = 1'b0;
			if (lat == 15)
				contend_in = 1'b0;
			if (per_sel_out === 1'b1)
				bus_seen = per_bus_out;
		end while (rsp_valid_out !== 1'b1 && lat < 60);
		chk("rsp_valid", 1, rsp_valid_out);
		chk("latency_in_range", 1, 32'(lat >= lo && lat <= hi));
		chk("rdata", {8'ha5, a}, rsp_rdata_out);
		chk("bus", a[15:13], bus_seen);
		@(negedge clk_in);
		chk("rsp_pulse", 0, rsp_valid_out);
	endtask

	task automatic t_reset;
		repeat (10) @(negedge clk_in);
		chk("empty_rst", 1, wq_empty_out);
		chk("rsp_rst", 0, rsp_valid_out);
		chk("sel_rst", 0, per_sel_out);
		rst_n_in = 1'b1;
	endtask

	// Six posted writes fill the four-entry queue and stall, then a read must wait
	task automatic t_fill;
		logic r;
		send(1'b1, 24'h080004, r);
		send(1'b1, 24'h081008, r);
		send(1'b1, 24'h082010, r);
		send(1'b1, 24'h084014, r);
		send(1'b1, 24'h081300, r);
		send(1'b1, 24'h08c018, r);
		// Settle past the accepting edge before looking
		#1;
		chk("empty_busy", 0, wq_empty_out);
		rd(24'h08c018, 7, 60, 1'b0);
	endtask

	task automatic t_plain;
		rd(24'h080004, 7, 7, 1'b1);
		rd(24'h081008, 8, 8, 1'b1);
		rd(24'h082010, 7, 7, 1'b1);
		rd(24'h081300, 8, 8, 1'b1);
	endtask

	task automatic t_sync;
		rd(24'h084014, 7, 11, 1'b1);
		rd(24'h08c018, 7, 15, 1'b1);
		pclk_div_in = 4'h1;
		rd(24'h084014, 7, 8, 1'b1);
		pclk_div_in = 4'h4;
	endtask

	task automatic t_contend;
		contend_in = 1'b1;
		rd(24'h084014, 12, 40, 1'b1);
	endtask

	task automatic end_sim;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		#(40 * 3000);
		fail_count++;
		end_sim();
	end

	initial
	begin
		t_reset();
		t_fill();
		t_plain();
		t_sync();
		t_contend();
		end_sim();
	end
endmodule
